/* lcdcd_pkg.sv */
// Constants and types of the segment display command decoder.
// Assumes nothing of its surroundings; the sequencer, top, checker and bench files import it whole.
package lcdcd_pkg;

	// Drive modes as coded in the low bits of the mode-set command
	localparam logic [1:0] LCDCD_MODE_STATIC = 2'h1;
	localparam logic [1:0] LCDCD_MODE_MUX2   = 2'h2;
	localparam logic [1:0] LCDCD_MODE_MUX3   = 2'h3;
	localparam logic [1:0] LCDCD_MODE_MUX4   = 2'h0;

	// Command byte field positions
	localparam int LCDCD_CONT_BIT   = 7;
	localparam int LCDCD_LP_BIT     = 4;
	localparam int LCDCD_EN_BIT     = 3;
	localparam int LCDCD_BIAS_BIT   = 2;
	localparam int LCDCD_IBANK_BIT  = 1;
	localparam int LCDCD_OBANK_BIT  = 0;
	localparam int LCDCD_BSTYLE_BIT = 2;

	// Opcode patterns
	localparam logic [1:0] LCDCD_OP_MODE   = 2'h2;
	localparam logic [1:0] LCDCD_OP_PTR    = 2'h0;
	localparam logic [3:0] LCDCD_OP_DEV    = 4'hc;
	localparam logic [4:0] LCDCD_OP_BANK   = 5'h1e;
	localparam logic [3:0] LCDCD_OP_BLINK  = 4'he;

	// Slave address upper six bits (011111x)
	localparam logic [5:0] LCDCD_SLAVE_HI  = 6'h1f;

	// Reset values of the status settings
	localparam logic [1:0] LCDCD_RST_MODE  = 2'h0;
	localparam logic [4:0] LCDCD_RST_PTR   = 5'h00;
	localparam logic [2:0] LCDCD_RST_SUB   = 3'h0;
	localparam logic [1:0] LCDCD_RST_BLINK = 2'h0;

	// Display RAM size and blink divider ratios at the display clock
	localparam int LCDCD_RAM_WORDS  = 24;
	localparam int LCDCD_BLINK_NORM = 92160;
	localparam int LCDCD_BLINK_LP   = 15360;

	// Receiver phase per transfer
	typedef enum logic [1:0] {
		LCDCD_ST_IDLE,
		LCDCD_ST_CMD,
		LCDCD_ST_DATA,
		LCDCD_ST_IGNORE
	} lcdcd_state_t;

endpackage

/* lcdcd_byte_if.sv */
// Byte stream carrier between the FIFO and the decoder.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface lcdcd_byte_if #(parameter int W = 10);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);
endinterface

/* lcdcd_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/10ps
module lcdcd_fifo #(
	parameter int W = 10,
	parameter int D = 32
) (
	// Clock and control
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// Fill side
	input  wire logic         in_valid,
	output      logic         in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	lcdcd_byte_if.src         out
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	wire push = in_valid && in_ready;
	wire pop  = out.valid && out.ready;

	// Status and output words
	assign in_ready  = (cnt_q != (AW+1)'(D));
	assign out.valid = (cnt_q != '0);
	assign out.data  = mem[rd_q];

	// Pointer and count update
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			if (push) begin
				mem[wr_q] <= in_data;
				wr_q      <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop)
				rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* lcdcd_sync.sv */
// Backplane phase sequencer with open-drain cascade sync line.
// Assumes the sync line input already sits in the clock domain.
`timescale 1ns/10ps
module lcdcd_sync #(
	parameter int PHASE_CYCLES = 4
) (
	// Clock and control
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [1:0] drive_mode,
	// Sync line
	input  wire logic       sync_in,
	output      logic       sync_oe,
	// Phase out
	output      logic [1:0] phase
);
	import lcdcd_pkg::*;

	localparam int CW = $clog2(PHASE_CYCLES + 1);
	logic [CW-1:0] cyc_q;
	logic [1:0]    ph_q;
	logic          sync_prev_q;
	logic [1:0]    last_ph;

	// Last phase per drive mode
	assign last_ph = (drive_mode == LCDCD_MODE_STATIC) ? 2'h0 :
	                 (drive_mode == LCDCD_MODE_MUX2)   ? 2'h1 :
	                 (drive_mode == LCDCD_MODE_MUX3)   ? 2'h2 : 2'h3;
	wire at_last   = (ph_q == last_ph);
	wire sync_fall = sync_prev_q && !sync_in;
	assign sync_oe = at_last && (cyc_q == '0); // RULE16 RULE18
	assign phase   = ph_q;

	// Phase counter; all devices leave reset at phase 0, cycle 0
	always_ff @(posedge clk) begin
		if (rst) begin
			cyc_q       <= '0; // RULE19
			ph_q        <= 2'h0;
			sync_prev_q <= 1'b1;
		end else if (ce) begin
			sync_prev_q <= sync_in;
			if (sync_fall && !sync_oe) begin
				ph_q  <= last_ph; // RULE17
				cyc_q <= CW'(1);
			end else if (cyc_q == CW'(PHASE_CYCLES - 1)) begin
				cyc_q <= '0;
				ph_q  <= at_last ? 2'h0 : ph_q + 1'b1;
			end else begin
				cyc_q <= cyc_q + 1'b1;
			end
		end
	end
endmodule

/* lcdcd_top.sv */
// Command decoder and display controller of a segment display driver.
// Assumes bus framing is done outside: bytes arrive with start/stop flags,
// and the slave address byte is the first byte after each start.
//
// Notes on behaviour
// RULE1 - Top bit of each command byte set means the next byte is a command.
// RULE2 - Top bit clear marks the final command; later bytes are display data.
// RULE3 - Mode set: bits 6..5 = 10; low two bits choose the drive mode.
// RULE4 - Mode set bit 2: zero gives one-third bias, one gives half bias.
// RULE5 - Mode set bit 3: zero blanks the display, one enables it.
// RULE6 - Mode set bit 4: zero normal power, one power saving.
// RULE7 - Load pointer: bits 6..5 = 00; five low bits go to RAM pointer.
// RULE8 - Device select: bits 6..3 = 1100; three low bits load subaddress counter.
// RULE9 - Bank select bit 1 picks the input bank for stored data.
// RULE10 - Bank select bit 0 picks the output bank shown on display.
// RULE11 - Bank select is ignored in three-way and four-way multiplex.
// RULE12 - Blink: bits 6..3 = 1110; two low bits set the blink rate.
// RULE13 - Blink bit 2: whole-display blink or bank alternation, not in mux3/mux4.
// RULE14 - Controller holds settings, applies commands and writes data to RAM.
// RULE15 - Up to sixteen drivers: three-bit subaddress plus address select pin.
// RULE16 - Pull sync at start of last backplane phase; monitor it otherwise.
// RULE17 - On lost alignment, realign to the first sync assertion seen.
// RULE18 - Sync is driven only low through an open-drain output.
// RULE19 - Drivers leave reset already aligned, with no sync needed.
// RULE20 - In data phase only the matching subaddress acknowledges and stores.
// RULE21 - Respond to slave address 011111x with x equal to address-select pin.
// RULE22 - Pointer and subaddress counter advance as display bytes are stored.
`timescale 1ns/10ps
module lcdcd_top #(
	parameter int FIFO_DEPTH   = 32,
	parameter int PHASE_CYCLES = 4,
	parameter int BLINK_DIV    = lcdcd_pkg::LCDCD_BLINK_NORM,
	parameter int BLINK_DIV_LP = lcdcd_pkg::LCDCD_BLINK_LP
) (
	// Clock, reset, enable
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	input  wire logic        CE,
	// Received byte stream from the bus framer
	input  wire logic        BYTE_VALID,
	output      logic        BYTE_READY,
	input  wire logic [7:0]  BYTE_DATA,
	input  wire logic        BYTE_FIRST,
	input  wire logic        BYTE_STOP,
	// Acknowledge decision per consumed byte
	output      logic        ACK_VALID,
	output      logic        ACK_ASSERT,
	// Straps
	input  wire logic        SLAVE_ADDR_LOW_PIN,
	input  wire logic        HW_SUBADDR_BIT0,
	input  wire logic        HW_SUBADDR_BIT1,
	input  wire logic        HW_SUBADDR_BIT2,
	// Status settings
	output      logic        DRIVE_MODE_HI,
	output      logic        DRIVE_MODE_LO,
	output      logic        BIAS_HALF,
	output      logic        DISPLAY_ENABLE,
	output      logic        LOW_POWER_SELECT,
	output      logic        BLINK_RATE_HI,
	output      logic        BLINK_RATE_LO,
	output      logic        BLINK_ALTERNATE,
	output      logic        INPUT_BANK,
	output      logic        OUTPUT_BANK,
	output      logic [4:0]  RAM_POINTER_VALUE,
	output      logic [2:0]  SUBADDR_COUNTER,
	// Display output
	output      logic        DISPLAY_VISIBLE,
	output      logic [1:0]  BACKPLANE_OUTPUT,
	output      logic [3:0]  SEGMENT_NIBBLE,
	input  wire logic [4:0]  SCAN_ADDR,
	// Cascade sync, open drain
	input  wire logic        SYNC_IN,
	output      logic        SYNC_OUT,
	output      logic        SYNC_OE
);
	import lcdcd_pkg::*;

	// ****************************************************************
	// Byte buffering
	// ****************************************************************
	// Stop and first flags travel beside each byte
	lcdcd_byte_if #(.W(10)) bq ();

	lcdcd_fifo #(.W(10), .D(FIFO_DEPTH)) u_fifo (
		.clk      (CLK_SYS),
		.rst      (RST),
		.ce       (CE),
		.in_valid (BYTE_VALID),
		.in_ready (BYTE_READY),
		.in_data  ({BYTE_STOP, BYTE_FIRST, BYTE_DATA}),
		.out      (bq.src)
	);

	// ****************************************************************
	// Decoding helpers
	// ****************************************************************
	// Three- and four-way modes have no spare bank
	function automatic logic is_mux34(input logic [1:0] m);
		return (m == LCDCD_MODE_MUX3) || (m == LCDCD_MODE_MUX4);
	endfunction

	// Pointer step with wrap after the last word
	function automatic logic [4:0] ptr_next(input logic [4:0] p);
		return (p == 5'(LCDCD_RAM_WORDS - 1)) ? 5'h00 : p + 5'h01;
	endfunction

	// Bits written per drive mode and input bank
	function automatic logic [3:0] bank_mask(input logic [1:0] m, input logic bank);
		if (is_mux34(m))
			return 4'hf;
		else if (m == LCDCD_MODE_STATIC)
			return bank ? 4'h4 : 4'h1;
		else
			return bank ? 4'hc : 4'h3;
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	// Phase, settings, acknowledge, display RAM and blink
	lcdcd_state_t st_q;
	lcdcd_state_t st_d;
	logic [1:0]   mode_q;
	logic         bias_q;
	logic         en_q;
	logic         lp_q;
	logic [1:0]   brate_q;
	logic         balt_q;
	logic         ibank_q;
	logic         obank_q;
	logic [4:0]   ptr_q;
	logic [2:0]   sub_q;
	logic         ack_v_q;
	logic         ack_a_q;
	logic [3:0]   ram [LCDCD_RAM_WORDS];
	logic [3:0]   seg_q;
	logic [18:0]  blink_cnt_q;
	logic         blink_ph_q;

	// ****************************************************************
	// Byte classification
	// ****************************************************************
	// Fields and opcode matches of the head byte
	wire       take    = bq.valid && CE;
	wire [7:0] b       = bq.data[7:0];
	wire       b_first = bq.data[8];
	wire       b_stop  = bq.data[9];
	wire [2:0] hw_sub  = {HW_SUBADDR_BIT2, HW_SUBADDR_BIT1, HW_SUBADDR_BIT0};
	wire       addr_ok = (b[7:2] == LCDCD_SLAVE_HI) && (b[1] == SLAVE_ADDR_LOW_PIN); // RULE21
	wire       is_cmd  = (st_q == LCDCD_ST_CMD);
	wire       is_data = (st_q == LCDCD_ST_DATA);
	wire       op_mode = is_cmd && (b[6:5] == LCDCD_OP_MODE);  // RULE3
	wire       op_ptr  = is_cmd && (b[6:5] == LCDCD_OP_PTR);   // RULE7
	wire       op_dev  = is_cmd && (b[6:3] == LCDCD_OP_DEV);   // RULE8
	wire       op_bank = is_cmd && (b[6:2] == LCDCD_OP_BANK) && !is_mux34(mode_q); // RULE11
	wire       op_blnk = is_cmd && (b[6:3] == LCDCD_OP_BLINK); // RULE12
	wire       mine    = (sub_q == hw_sub); // RULE15 RULE20
	wire       store   = take && is_data && mine;
	assign bq.ready = CE;

	// ****************************************************************
	// Transfer phase sequencing
	// ****************************************************************
	// Next phase for each byte taken
	always_comb begin
		st_d = st_q;
		if (take) begin
			if (b_first)
				st_d = addr_ok ? LCDCD_ST_CMD : LCDCD_ST_IGNORE;
			else
				unique case (st_q)
					LCDCD_ST_IDLE:   st_d = LCDCD_ST_IDLE;
					LCDCD_ST_CMD:    st_d = b[LCDCD_CONT_BIT] ? LCDCD_ST_CMD
					                                          : LCDCD_ST_DATA; // RULE1 RULE2
					LCDCD_ST_DATA:   st_d = LCDCD_ST_DATA; // RULE2
					LCDCD_ST_IGNORE: st_d = LCDCD_ST_IGNORE;
				endcase
			if (b_stop)
				st_d = LCDCD_ST_IDLE;
		end
	end

	// Phase register
	always_ff @(posedge CLK_SYS) begin
		if (RST)
			st_q <= LCDCD_ST_IDLE;
		else if (CE)
			st_q <= st_d;
	end

	// ****************************************************************
	// Acknowledge decision
	// ****************************************************************
	// One decision per byte taken
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			ack_v_q <= 1'b0;
			ack_a_q <= 1'b0;
		end else if (CE) begin
			ack_v_q <= take;
			ack_a_q <= take && ((b_first && addr_ok) || is_cmd || (is_data && mine)); // RULE20
		end
	end

	// ****************************************************************
	// Status settings
	// ****************************************************************
	// Command fields into the status settings
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			mode_q  <= LCDCD_RST_MODE;
			bias_q  <= 1'b0;
			en_q    <= 1'b0;
			lp_q    <= 1'b0;
			brate_q <= LCDCD_RST_BLINK;
			balt_q  <= 1'b0;
			ibank_q <= 1'b0;
			obank_q <= 1'b0;
		end else if (take && !b_first) begin // RULE14
			if (op_mode) begin
				mode_q <= b[1:0];              // RULE3
				bias_q <= b[LCDCD_BIAS_BIT];   // RULE4
				en_q   <= b[LCDCD_EN_BIT];     // RULE5
				lp_q   <= b[LCDCD_LP_BIT];     // RULE6
			end
			if (op_bank) begin
				ibank_q <= b[LCDCD_IBANK_BIT]; // RULE9
				obank_q <= b[LCDCD_OBANK_BIT]; // RULE10
			end
			if (op_blnk) begin
				brate_q <= b[1:0];             // RULE12
				balt_q  <= b[LCDCD_BSTYLE_BIT]; // RULE13
			end
		end
	end

	// ****************************************************************
	// Pointer and subaddress counter
	// ****************************************************************
	// Last word reached, next byte goes to the next driver
	wire ptr_wrap = (ptr_q == 5'(LCDCD_RAM_WORDS - 1));

	// Loaded by command; pointer stepped by every data byte, subaddress counter at pointer wrap
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			ptr_q <= LCDCD_RST_PTR;
			sub_q <= LCDCD_RST_SUB;
		end else if (take && !b_first) begin
			if (op_ptr)
				ptr_q <= b[4:0]; // RULE7
			if (op_dev)
				sub_q <= b[2:0]; // RULE8
			if (is_data) begin
				ptr_q <= ptr_next(ptr_q); // RULE22
				if (ptr_wrap)
					sub_q <= sub_q + 3'h1; // RULE22
			end
		end
	end

	// ****************************************************************
	// Display RAM
	// ****************************************************************
	// Input bank mask and shift, merged with the old word
	wire       bank_mux = !is_mux34(mode_q);
	wire [3:0] wr_mask  = bank_mask(mode_q, ibank_q); // RULE9
	wire [3:0] wr_shift = (ibank_q && bank_mux) ? {b[1:0], 2'h0} : b[3:0];
	wire [3:0] wr_word  = (ram[ptr_q] & ~wr_mask) | (wr_shift & wr_mask);

	// Output bank, swapped on the blink phase when alternating
	wire       alt_now  = balt_q && bank_mux && blink_ph_q; // RULE13
	wire       out_bank = obank_q ^ alt_now;                // RULE10
	wire [3:0] rd_word  = ram[SCAN_ADDR < 5'(LCDCD_RAM_WORDS) ? SCAN_ADDR : 5'h00];
	wire [3:0] rd_shown = (bank_mux && out_bank) ? {2'h0, rd_word[3:2]} : rd_word;

	// Store one data byte; register the scanned word
	always_ff @(posedge CLK_SYS) begin
		if (CE) begin
			if (store)
				ram[ptr_q] <= wr_word; // RULE14
			seg_q <= rd_shown;
		end
	end

	// ****************************************************************
	// Blink timebase
	// ****************************************************************
	// Half period per rate; the slowest rate needs all 19 bits
	wire [18:0] div_base = lp_q ? 19'(BLINK_DIV_LP) : 19'(BLINK_DIV);
	wire [18:0] div_full = div_base << (brate_q - 2'h1);
	wire        blink_tc = (blink_cnt_q >= div_full - 19'h1);

	// Blink counter and phase
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			blink_cnt_q <= '0;
			blink_ph_q  <= 1'b0;
		end else if (CE) begin
			if (brate_q == 2'h0 || blink_tc) begin
				blink_cnt_q <= '0;
				blink_ph_q  <= (brate_q == 2'h0) ? 1'b0 : !blink_ph_q;
			end else begin
				blink_cnt_q <= blink_cnt_q + 19'h1;
			end
		end
	end

	// ****************************************************************
	// Backplane sequencing
	// ****************************************************************
	// Phase sequencer follows the current drive mode
	lcdcd_sync #(.PHASE_CYCLES(PHASE_CYCLES)) u_sync (
		.clk        (CLK_SYS),
		.rst        (RST),
		.ce         (CE),
		.drive_mode (mode_q),
		.sync_in    (SYNC_IN),
		.sync_oe    (SYNC_OE),
		.phase      (BACKPLANE_OUTPUT)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Register levels straight to the pins, except SYNC_OUT tied low and DISPLAY_VISIBLE gated by blink
	assign SYNC_OUT          = 1'b0; // RULE18
	assign ACK_VALID         = ack_v_q;
	assign ACK_ASSERT        = ack_a_q;
	assign DRIVE_MODE_HI     = mode_q[1];
	assign DRIVE_MODE_LO     = mode_q[0];
	assign BIAS_HALF         = bias_q;
	assign DISPLAY_ENABLE    = en_q;
	assign LOW_POWER_SELECT  = lp_q;
	assign BLINK_RATE_HI     = brate_q[1];
	assign BLINK_RATE_LO     = brate_q[0];
	assign BLINK_ALTERNATE   = balt_q;
	assign INPUT_BANK        = ibank_q;
	assign OUTPUT_BANK       = obank_q;
	assign RAM_POINTER_VALUE = ptr_q;
	assign SUBADDR_COUNTER   = sub_q;
	assign SEGMENT_NIBBLE    = seg_q;
	assign DISPLAY_VISIBLE   = en_q && !(blink_ph_q && !balt_q); // RULE5 RULE13
endmodule

/* lcdcd_assertions.sv */
// Concurrent checks on the ports of the display command decoder top.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
module lcdcd_assertions (
	// Clock, reset, enable
	input	wire logic		CLK_SYS,
	input	wire logic		RST,
	input	wire logic		CE,
	// Byte stream and acknowledge
	input	wire logic		BYTE_READY,
	input	wire logic		ACK_VALID,
	input	wire logic		ACK_ASSERT,
	// Status settings
	input	wire logic		DRIVE_MODE_HI,
	input	wire logic		DRIVE_MODE_LO,
	input	wire logic		BIAS_HALF,
	input	wire logic		DISPLAY_ENABLE,
	input	wire logic		LOW_POWER_SELECT,
	input	wire logic		BLINK_RATE_HI,
	input	wire logic		BLINK_RATE_LO,
	input	wire logic		BLINK_ALTERNATE,
	input	wire logic		INPUT_BANK,
	input	wire logic		OUTPUT_BANK,
	input	wire logic [4:0]	RAM_POINTER_VALUE,
	input	wire logic [2:0]	SUBADDR_COUNTER,
	// Display and cascade sync
	input	wire logic		DISPLAY_VISIBLE,
	input	wire logic [1:0]	BACKPLANE_OUTPUT,
	input	wire logic		SYNC_IN,
	input	wire logic		SYNC_OUT,
	input	wire logic		SYNC_OE
);
	import lcdcd_pkg::*;
	// ****************************************
	// Helper wires and checks
	// ****************************************
	wire logic [1:0]	mode = {DRIVE_MODE_HI, DRIVE_MODE_LO};
	wire logic [1:0]	last_ph = (mode == LCDCD_MODE_MUX4) ? 2'h3 : mode - 2'h1;
	wire logic		two_banks = (mode == LCDCD_MODE_STATIC) || (mode == LCDCD_MODE_MUX2);
	wire logic [17:0]	sets = {mode, BIAS_HALF, DISPLAY_ENABLE, LOW_POWER_SELECT,
		BLINK_RATE_HI, BLINK_RATE_LO, BLINK_ALTERNATE, INPUT_BANK, OUTPUT_BANK,
		RAM_POINTER_VALUE, SUBADDR_COUNTER};
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	reset_clear_a: assert property (disable iff (1'b0) RST && CE |=>
		sets == 18'h0 && BACKPLANE_OUTPUT == 2'h0 && !ACK_VALID && BYTE_READY)
		else $error("state not cleared by reset");
	sync_low_a: assert property (SYNC_OUT == 1'b0)
		else $error("sync line driven high");
	sync_pulse_a: assert property (CE && SYNC_OE |->
		BACKPLANE_OUTPUT == last_ph ##1 !SYNC_OE)
		else $error("sync pull outside first cycle of last phase");
	sync_realign_a: assert property (CE && $fell(SYNC_IN) && !SYNC_OE |->
		##[1:2] BACKPLANE_OUTPUT == last_ph)
		else $error("no realign to foreign sync");
	ce_freeze_a: assert property (!CE |=> $stable(BACKPLANE_OUTPUT) &&
		$stable(RAM_POINTER_VALUE) && $stable(SUBADDR_COUNTER))
		else $error("state moved with enable low");
	ack_qual_a: assert property (ACK_ASSERT |-> ACK_VALID)
		else $error("acknowledge without consumed byte");
	ptr_range_a: assert property (RAM_POINTER_VALUE <= 5'h17)
		else $error("pointer beyond last word");
	bank_hold_a: assert property (!$past(RST) && !$stable({INPUT_BANK, OUTPUT_BANK}) |->
		$past(two_banks))
		else $error("bank changed in three or four way mode");
	visible_en_a: assert property (DISPLAY_VISIBLE |-> DISPLAY_ENABLE)
		else $error("display shown while blanked");

	// Main scenarios
	ack_seen_c: cover property (ACK_VALID && ACK_ASSERT);
	nack_seen_c: cover property (ACK_VALID && !ACK_ASSERT);
	sync_drive_c: cover property (SYNC_OE);
endmodule

bind lcdcd_top lcdcd_assertions i_chk (.*);

/* lcdcd_master.sv */
// Byte-level model of the bus master feeding the decoder.
// Assumes inputs change at the falling clock edge.
`timescale 1ns/10ps
module lcdcd_master (
	// Clock and handshake
	input	wire logic		clk,
	input	wire logic		ready,
	// Byte stream
	output	logic			valid,
	output	logic [7:0]		data,
	output	logic			first,
	output	logic			stop
);
	int gap = 0;
	// ****************************************
	// Idle line and byte sender
	// ****************************************
	initial begin
		valid = 1'b0;
		data = 8'h00;
		first = 1'b0;
		stop = 1'b0;
	end

	// Hold the byte until a rising edge sees ready, then release or chain
	task automatic send(input logic [7:0] b, input logic f, input logic s);
		int k;
		repeat (gap) @(negedge clk);
		valid = 1'b1;
		data = b;
		first = f;
		stop = s;
		for (k = 0; k < 100 && ready !== 1'b1; k++) @(negedge clk);
		@(negedge clk);
		if (gap != 0 || s) begin
			valid = 1'b0;
			data = ~b;
			first = 1'b0;
			stop = 1'b0;
		end
	endtask
endmodule

/* lcdcd_top_test.sv */
// Self-checking bench of the display command decoder top.
// Assumes the checker bind and the master model are compiled before it.
`timescale 1ns/10ps
module lcdcd_top_test;
	import lcdcd_pkg::*;
	typedef struct {logic [7:0] c; logic [17:0] e;} lcdcd_row_t;
	logic CLK_SYS = 1'b0;
	logic RST, CE, SLAVE_ADDR_LOW_PIN, HW_SUBADDR_BIT0, HW_SUBADDR_BIT1, HW_SUBADDR_BIT2;
	logic [4:0] SCAN_ADDR;
	logic sync_pull;
	logic [1:0] ph;
	wire logic BYTE_VALID, BYTE_READY, BYTE_FIRST, BYTE_STOP, ACK_VALID, ACK_ASSERT;
	wire logic [7:0] BYTE_DATA;
	wire logic DRIVE_MODE_HI, DRIVE_MODE_LO, BIAS_HALF, DISPLAY_ENABLE, LOW_POWER_SELECT;
	wire logic BLINK_RATE_HI, BLINK_RATE_LO, BLINK_ALTERNATE, INPUT_BANK, OUTPUT_BANK;
	wire logic [4:0] RAM_POINTER_VALUE;
	wire logic [2:0] SUBADDR_COUNTER;
	wire logic DISPLAY_VISIBLE, SYNC_OUT, SYNC_OE;
	wire logic [1:0] BACKPLANE_OUTPUT;
	wire logic [3:0] SEGMENT_NIBBLE;
	wire logic SYNC_IN = !((SYNC_OE && !SYNC_OUT) || sync_pull);
	wire logic [17:0] st = {DRIVE_MODE_HI, DRIVE_MODE_LO, BIAS_HALF, DISPLAY_ENABLE,
		LOW_POWER_SELECT, BLINK_RATE_HI, BLINK_RATE_LO, BLINK_ALTERNATE, INPUT_BANK,
		OUTPUT_BANK, RAM_POINTER_VALUE, SUBADDR_COUNTER};
	int n_mismatch = 0;
	int n_tests = 0;
	logic [7:0] bq[$];
	logic acks[$];
	lcdcd_row_t rows[12];

	// ****************************************
	// Clock, design, master, helpers
	// ****************************************
	always #2.5 CLK_SYS = ~CLK_SYS;

	lcdcd_top #(.BLINK_DIV(8), .BLINK_DIV_LP(4)) i_dut (.*);
	lcdcd_master i_mst (.clk(CLK_SYS), .ready(BYTE_READY), .valid(BYTE_VALID),
		.data(BYTE_DATA), .first(BYTE_FIRST), .stop(BYTE_STOP));

	// Record each acknowledge decision
	always @(negedge CLK_SYS) begin
		if (ACK_VALID === 1'b1) begin
			acks.push_back(ACK_ASSERT);
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask

	// Send the queued transfer and compare the acknowledge pattern
	task automatic run(input logic [6:0] ea);
		logic [6:0] ga;
		int k;
		ga = 7'h00;
		acks.delete();
		foreach (bq[i]) i_mst.send(bq[i], i == 0, i == bq.size() - 1);
		for (k = 0; k < 60 && acks.size() < bq.size(); k++) @(negedge CLK_SYS);
		@(negedge CLK_SYS);
		foreach (acks[i]) ga[i] = acks[i];
		chk("ack", ea, ga);
	endtask

	task automatic rst_dut(input int n);
		RST = 1'b1;
		repeat (n) @(negedge CLK_SYS);
		RST = 1'b0;
		chk("reset state", 18'h0, st);
		chk("reset phase", 2'h0, BACKPLANE_OUTPUT);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Cut a hang short
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end

	// ****************************************
	// Stimulus
	// ****************************************
	initial begin
		CE = 1'b1;
		SLAVE_ADDR_LOW_PIN = 1'b0;
		HW_SUBADDR_BIT0 = 1'b0;
		HW_SUBADDR_BIT1 = 1'b0;
		HW_SUBADDR_BIT2 = 1'b0;
		SCAN_ADDR = 5'h00;
		sync_pull = 1'b0;
		rows[0] = '{8'h49, {5'b01010, 3'b000, 2'b00, 5'd0, 3'd0}};
		rows[1] = '{8'h7b, {5'b01010, 3'b000, 2'b11, 5'd0, 3'd0}};
		rows[2] = '{8'h75, {5'b01010, 3'b011, 2'b11, 5'd0, 3'd0}};
		rows[3] = '{8'h17, {5'b01010, 3'b011, 2'b11, 5'd23, 3'd0}};
		rows[4] = '{8'h65, {5'b01010, 3'b011, 2'b11, 5'd23, 3'd5}};
		rows[5] = '{8'h5e, {5'b10111, 3'b011, 2'b11, 5'd23, 3'd5}};
		rows[6] = '{8'h72, {5'b10111, 3'b100, 2'b11, 5'd23, 3'd5}};
		rows[7] = '{8'h53, {5'b11001, 3'b100, 2'b11, 5'd23, 3'd5}};
		rows[8] = '{8'h78, {5'b11001, 3'b100, 2'b11, 5'd23, 3'd5}};
		rows[9] = '{8'h73, {5'b11001, 3'b110, 2'b11, 5'd23, 3'd5}};
		rows[10] = '{8'h70, {5'b11001, 3'b000, 2'b11, 5'd23, 3'd5}};
		rows[11] = '{8'h40, {5'b00000, 3'b000, 2'b11, 5'd23, 3'd5}};
		rst_dut(5);
		chk("ready", 1'b1, BYTE_READY);
		for (int r = 0; r < 12; r++) begin
			bq = {8'h7c, rows[r].c};
			run(7'h03);
			chk("settings", rows[r].e, st);
		end
		// Chained commands, then data with pointer wrap and subaddress mismatch
		i_mst.gap = 3;
		bq = {8'h7c, 8'he0, 8'h96, 8'h48, 8'hc7, 8'h8d, 8'h4b};
		run(7'h3f);
		chk("chain settings", {5'b00010, 3'b000, 2'b11, 5'd1, 3'd1}, st);
		i_mst.gap = 0;
		SCAN_ADDR = 5'd22;
		repeat (2) @(negedge CLK_SYS);
		chk("word 22", 4'h7, SEGMENT_NIBBLE);
		SCAN_ADDR = 5'd23;
		repeat (2) @(negedge CLK_SYS);
		chk("word 23", 4'hd, SEGMENT_NIBBLE);
		// Foreign slave address ignored, own one taken
		bq = {8'h7e, 8'h4f};
		run(7'h00);
		chk("foreign settings", {5'b00010, 3'b000, 2'b11, 5'd1, 3'd1}, st);
		SLAVE_ADDR_LOW_PIN = 1'b1;
		run(7'h03);
		chk("own settings", {5'b11110, 3'b000, 2'b11, 5'd1, 3'd1}, st);
		chk("visible", 1'b1, DISPLAY_VISIBLE);
		// Whole-display blink at the fastest rate
		bq = {8'h7e, 8'h71};
		run(7'h03);
		for (int k = 0; k < 20 && DISPLAY_VISIBLE !== 1'b0; k++) @(negedge CLK_SYS);
		chk("blink off half", 1'b0, DISPLAY_VISIBLE);
		for (int k = 0; k < 20 && DISPLAY_VISIBLE !== 1'b1; k++) @(negedge CLK_SYS);
		chk("blink on half", 1'b1, DISPLAY_VISIBLE);
		rst_dut(1);
		// Own sync pull, then realign to a foreign pull
		for (int k = 0; k < 40 && SYNC_OE !== 1'b1; k++) @(negedge CLK_SYS);
		chk("sync phase", 2'h3, BACKPLANE_OUTPUT);
		for (int k = 0; k < 40 && BACKPLANE_OUTPUT !== 2'h1; k++) @(negedge CLK_SYS);
		sync_pull = 1'b1;
		@(negedge CLK_SYS);
		sync_pull = 1'b0;
		@(negedge CLK_SYS);
		chk("realigned", 2'h3, BACKPLANE_OUTPUT);
		// Enable low freezes the phase
		ph = BACKPLANE_OUTPUT;
		CE = 1'b0;
		repeat (6) @(negedge CLK_SYS);
		chk("frozen phase", ph, BACKPLANE_OUTPUT);
		CE = 1'b1;
		end_sim();
	end
endmodule
